// ===== core/lcd_top.v
/*
 led capacity display: enable mode, activity detect, bank drive.
 assumes charge, reference, temperature, sense and flags come from
 gauge logic on REF_CLK; only the display enable pin is asynchronous.
*/
`include "lcd_defs.vh"

// Functional notes
// - each of five segments stands for one fifth of the full reference
// - temperature scales shown capacity only, never the stored charge count
// - enable pin at supply level keeps all segments dark
// - floating enable lights display on discharge below -4 mV or valid charge
// - enable pin pulled low lights the display at once
// - banks alternate: segments one, three, five versus two and four
// - banks repeat near 100 Hz, each driven about 30% of period
// - first empty warning blinks segment one at 4 Hz
// - final empty warning blanks the display entirely
// - default thresholds 375 uV and -300 uV, overridable by filter register
// - full reference is the learned last-measured-discharge value
module lcd_top #(
   parameter MUX_CYC = `LCD_MUX_CYC,
   parameter BLINK_HALF_CYC = `LCD_BLINK_HALF_CYC
) (
   input wire REF_CLK,
   input wire RESETN,
   input wire DISPLAY_ENABLE_N,
   input wire DISPLAY_ENABLE_FLOAT,
   input wire [15:0] AVAILABLE_CHARGE_COUNT,
   input wire [15:0] LEARNED_FULL_CAPACITY,
   input wire [3:0] TEMPERATURE_GAUGE_REG,
   input wire [7:0] MAGNITUDE_FILTER_REG,
   input wire signed [23:0] SENSE_RATE_UV,
   input wire FIRST_EMPTY_FLAG,
   input wire FINAL_EMPTY_FLAG,
   output reg [4:0] LED_SEGMENT_OUT,
   output reg LED_COMMON_OUT,
   output reg DISPLAY_ACTIVE
);

   // ----------------------------------------
   // states
   // ----------------------------------------
   localparam [2:0] ST_DARK = 3'h1;
   localparam [2:0] ST_SHOW = 3'h2;
   localparam [2:0] ST_BLANK = 3'h4;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   reg en_n_s1_r;
   reg en_n_s2_r;
   reg flt_s1_r;
   reg flt_s2_r;

   // resets to the dark level so no false show follows reset
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         en_n_s1_r <= 1'b1;
         en_n_s2_r <= 1'b1;
      end else begin
         en_n_s1_r <= DISPLAY_ENABLE_N;
         en_n_s2_r <= en_n_s1_r;
      end
   end

   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         flt_s1_r <= 1'b0;
         flt_s2_r <= 1'b0;
      end else begin
         flt_s1_r <= DISPLAY_ENABLE_FLOAT;
         flt_s2_r <= flt_s1_r;
      end
   end

   // ----------------------------------------
   // enable mode decode
   // ----------------------------------------
   // floating wins over level: a floating pin reads as either level
   reg mode_float;
   reg mode_on;
   reg mode_off;

   always @* begin
      mode_float = 1'b0;
      mode_on = 1'b0;
      mode_off = 1'b0;
      case ({flt_s2_r, en_n_s2_r})
         2'h0: begin
            mode_on = 1'b1;
         end
         2'h1: begin
            mode_off = 1'b1;
         end
         default: begin
            mode_float = 1'b1;
         end
      endcase
   end

   // ----------------------------------------
   // filter thresholds
   // ----------------------------------------
   // zero in the filter register keeps the factory defaults
   function signed [23:0] filt_thr;
      input [7:0] filt;
      input signed [23:0] dflt;
      input neg;
      reg signed [23:0] mag;
      begin
         mag = $signed({16'h0000, filt}) * `LCD_FILT_STEP_UV;
         if (filt == 8'h00) begin
            filt_thr = dflt;
         end else if (neg) begin
            filt_thr = -mag;
         end else begin
            filt_thr = mag;
         end
      end
   endfunction

   reg signed [23:0] valid_charge_threshold_r;
   reg signed [23:0] valid_discharge_threshold_r;

   // one edge of lag after a filter write; harmless against sense rates
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         valid_charge_threshold_r <= `LCD_CHG_THR_DEF_UV;
      end else begin
         valid_charge_threshold_r <= filt_thr(MAGNITUDE_FILTER_REG, `LCD_CHG_THR_DEF_UV, 1'b0);
      end
   end

   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         valid_discharge_threshold_r <= `LCD_DIS_THR_DEF_UV;
      end else begin
         valid_discharge_threshold_r <= filt_thr(MAGNITUDE_FILTER_REG, `LCD_DIS_THR_DEF_UV, 1'b1);
      end
   end

   // ----------------------------------------
   // activity detect
   // ----------------------------------------
   reg activity_r;
   reg activity_nxt;
   reg discharge_seen;
   reg charge_seen;

   // the -300 uV limit gates the count; -4 mV gates the display
   always @* begin
      discharge_seen = (SENSE_RATE_UV < valid_discharge_threshold_r) &&
                       (SENSE_RATE_UV < `LCD_ACT_DIS_UV);
      charge_seen = (SENSE_RATE_UV > valid_charge_threshold_r);
      activity_nxt = discharge_seen | charge_seen;
   end

   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         activity_r <= 1'b0;
      end else begin
         activity_r <= activity_nxt;
      end
   end

   // ----------------------------------------
   // bar graph and timing
   // ----------------------------------------
   wire [4:0] lit;
   wire bank_a;
   wire bank_b;
   wire blink;

   lcd_scale u_scale (
      .clk(REF_CLK),
      .rst_n(RESETN),
      .chg_cnt(AVAILABLE_CHARGE_COUNT),
      .full_ref(LEARNED_FULL_CAPACITY),
      .temp(TEMPERATURE_GAUGE_REG),
      .lit_r(lit)
   );

   lcd_mux #(
      .MUX_CYC(MUX_CYC),
      .BLINK_HALF_CYC(BLINK_HALF_CYC)
   ) u_mux (
      .clk(REF_CLK),
      .rst_n(RESETN),
      .bank_a_r(bank_a),
      .bank_b_r(bank_b),
      .blink_r(blink)
   );

   // ----------------------------------------
   // display state machine
   // ----------------------------------------
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg want_show;

   always @* begin
      want_show = mode_on | (mode_float & activity_r);
      state_nxt = state_r;
      case (state_r)
         ST_DARK: begin
            if (FINAL_EMPTY_FLAG) begin
               state_nxt = ST_BLANK;
            end else if (want_show) begin
               state_nxt = ST_SHOW;
            end
         end
         ST_SHOW: begin
            if (FINAL_EMPTY_FLAG) begin
               state_nxt = ST_BLANK;
            end else if (mode_off | ~want_show) begin
               state_nxt = ST_DARK;
            end
         end
         ST_BLANK: begin
            if (!FINAL_EMPTY_FLAG) begin
               state_nxt = ST_DARK;
            end
         end
         default: begin
            state_nxt = ST_DARK;
         end
      endcase
   end

   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_r <= ST_DARK;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ----------------------------------------
   // segment drive
   // ----------------------------------------
   reg [4:0] seg_nxt;
   reg [4:0] bank_mask;
   reg com_nxt;
   reg shown;

   // bank a has priority; the timer never raises both at once
   function [4:0] bank_sel;
      input a;
      input b;
      begin
         bank_sel = 5'h0_0;
         if (a) begin
            bank_sel = `LCD_BANK_A_MASK;
         end else if (b) begin
            bank_sel = `LCD_BANK_B_MASK;
         end
      end
   endfunction

   always @* begin
      shown = (state_r == ST_SHOW) & ~mode_off;
      bank_mask = bank_sel(bank_a, bank_b);
      seg_nxt = lit & bank_mask;
      if (FIRST_EMPTY_FLAG && !blink) begin
         seg_nxt[0] = 1'b0;
      end
      if (!shown) begin
         seg_nxt = 5'h0_0;
      end
      com_nxt = shown & (bank_a | bank_b);
   end

   // ----------------------------------------
   // output registers
   // ----------------------------------------
   // all three share one stage so segments and common never skew
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         LED_SEGMENT_OUT <= 5'h0_0;
      end else begin
         LED_SEGMENT_OUT <= seg_nxt;
      end
   end

   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         LED_COMMON_OUT <= 1'b0;
      end else begin
         LED_COMMON_OUT <= com_nxt;
      end
   end

   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         DISPLAY_ACTIVE <= 1'b0;
      end else begin
         DISPLAY_ACTIVE <= shown;
      end
   end

endmodule // lcd_top

// ===== shared/lcd_defs.vh
/*
 constants of the led capacity display: timing, thresholds, bar geometry.
 assumes a 125 mhz reference clock and microvolt-scaled sense values.
*/
`ifndef LCD_DEFS_VH
`define LCD_DEFS_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define LCD_CLK_PERIOD_NS 8
`define LCD_MUX_PERIOD_NS 10000000
`define LCD_MUX_CYC (`LCD_MUX_PERIOD_NS / `LCD_CLK_PERIOD_NS)
`define LCD_BANK_ON_PCT 30
`define LCD_BANK_B_START_PCT 50
`define LCD_BLINK_PERIOD_NS 250000000
`define LCD_BLINK_HALF_CYC ((`LCD_BLINK_PERIOD_NS / 2) / `LCD_CLK_PERIOD_NS)

// ----------------------------------------
// bar graph
// ----------------------------------------
`define LCD_SEG_COUNT 5
`define LCD_TEMP_FRAC_BITS 6
`define LCD_BANK_A_MASK 5'h15
`define LCD_BANK_B_MASK 5'h0A

// ----------------------------------------
// sense thresholds, signed microvolts
// ----------------------------------------
`define LCD_SENSE_W 24
`define LCD_CHG_THR_DEF_UV 24'sd375
`define LCD_DIS_THR_DEF_UV -24'sd300
`define LCD_ACT_DIS_UV -24'sd4000
`define LCD_FILT_STEP_UV 24'sd5

`endif

// ===== core/lcd_scale.v
/*
 temperature-adjusted bar graph: which of the five segments are lit.
 assumes charge and reference come from logic on the same clock.
*/
`include "lcd_defs.vh"

module lcd_scale (
   input wire clk,
   input wire rst_n,
   input wire [15:0] chg_cnt,
   input wire [15:0] full_ref,
   input wire [3:0] temp,
   output reg [4:0] lit_r
);

   // ----------------------------------------
   // temperature derating, 64ths
   // ----------------------------------------
   // cold cells give less usable charge; the count itself is untouched
   function [6:0] derate;
      input [3:0] t;
      begin
         case (t)
            4'h0: derate = 7'h20;
            4'h1: derate = 7'h26;
            4'h2: derate = 7'h2C;
            4'h3: derate = 7'h32;
            4'h4: derate = 7'h38;
            4'h5: derate = 7'h3C;
            default: derate = 7'h40;
         endcase
      end
   endfunction

   wire [22:0] prod = chg_cnt * derate(temp);
   wire [16:0] adj = prod[22:6];
   wire [19:0] adj5 = adj * 3'h5;
   reg [4:0] lit_nxt;
   reg [19:0] thr;
   integer n;

   // ----------------------------------------
   // fifths of the learned reference
   // ----------------------------------------
   always @* begin
      lit_nxt = 5'h0_0;
      thr = 20'h0_0000;
      for (n = 0; n < `LCD_SEG_COUNT; n = n + 1) begin
         thr = full_ref * n[2:0];
         lit_nxt[n] = (adj != 17'h0_0000) && (adj5 >= thr);
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lit_r <= 5'h0_0;
      end else begin
         lit_r <= lit_nxt;
      end
   end

endmodule // lcd_scale

// ===== core/lcd_mux.v
/*
 bank multiplex timer and low-battery blink timer.
 assumes the periods are given in reference clock cycles.
*/
`include "lcd_defs.vh"

module lcd_mux #(
   parameter MUX_CYC = `LCD_MUX_CYC,
   parameter BLINK_HALF_CYC = `LCD_BLINK_HALF_CYC
) (
   input wire clk,
   input wire rst_n,
   output reg bank_a_r,
   output reg bank_b_r,
   output reg blink_r
);

   localparam [31:0] P_LAST_W = MUX_CYC - 1;
   localparam [31:0] A_END_W = (MUX_CYC * `LCD_BANK_ON_PCT) / 100;
   localparam [31:0] B_BEG_W = (MUX_CYC * `LCD_BANK_B_START_PCT) / 100;
   localparam [31:0] K_LAST_W = BLINK_HALF_CYC - 1;
   localparam [23:0] P_LAST = P_LAST_W[23:0];
   localparam [23:0] A_END = A_END_W[23:0];
   localparam [23:0] B_BEG = B_BEG_W[23:0];
   localparam [23:0] B_END = B_BEG + A_END;
   localparam [23:0] K_LAST = K_LAST_W[23:0];

   reg [23:0] mux_cnt_r;
   reg [23:0] blink_cnt_r;

   // ----------------------------------------
   // counters
   // ----------------------------------------
   // gaps between banks stop ghosting as the drive swaps
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mux_cnt_r <= 24'h00_0000;
         blink_cnt_r <= 24'h00_0000;
         bank_a_r <= 1'b0;
         bank_b_r <= 1'b0;
         blink_r <= 1'b0;
      end else begin
         mux_cnt_r <= (mux_cnt_r == P_LAST) ? 24'h00_0000 : mux_cnt_r + 24'h00_0001;
         bank_a_r <= (mux_cnt_r < A_END);
         bank_b_r <= (mux_cnt_r >= B_BEG) && (mux_cnt_r < B_END);
         if (blink_cnt_r == K_LAST) begin
            blink_cnt_r <= 24'h00_0000;
            blink_r <= ~blink_r;
         end else begin
            blink_cnt_r <= blink_cnt_r + 24'h00_0001;
         end
      end
   end

endmodule // lcd_mux

// ===== tb/lcd_top_props.sv
/*
 assertion checker for the led capacity display top.
 assumes a bind onto lcd_top and one REF_CLK domain.
*/
module lcd_top_props (
   input logic REF_CLK,
   input logic RESETN,
   input logic DISPLAY_ENABLE_N,
   input logic DISPLAY_ENABLE_FLOAT,
   input logic [15:0] AVAILABLE_CHARGE_COUNT,
   input logic signed [23:0] SENSE_RATE_UV,
   input logic FINAL_EMPTY_FLAG,
   input logic [4:0] LED_SEGMENT_OUT,
   input logic LED_COMMON_OUT,
   input logic DISPLAY_ACTIVE
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);
   // ------------------------------
   // bank window length
   // ------------------------------
   logic [7:0] run_r;
   logic [7:0] run_nxt;
   assign run_nxt = LED_COMMON_OUT ? run_r + 8'h01 : 8'h00;
   always_ff @(posedge REF_CLK or negedge RESETN)
      if (!RESETN)
         run_r <= 8'h00;
      else
         run_r <= run_nxt;
   // ------------------------------
   // properties
   // ------------------------------
   // sync plus state plus output register is four edges, six leaves slack
   property p_tied_dark;
      (DISPLAY_ENABLE_N && !DISPLAY_ENABLE_FLOAT)[*6] |-> !DISPLAY_ACTIVE && LED_SEGMENT_OUT == 5'h00;
   endproperty
   a_tied_dark: assert property (p_tied_dark) else $error("lit with pin high");
   property p_pulled_on;
      (!DISPLAY_ENABLE_N && !DISPLAY_ENABLE_FLOAT && !FINAL_EMPTY_FLAG)[*6] |-> DISPLAY_ACTIVE;
   endproperty
   a_pulled_on: assert property (p_pulled_on) else $error("dark with pin low");
   property p_float_idle;
      (DISPLAY_ENABLE_FLOAT && SENSE_RATE_UV == 24'sh00_0000)[*6] |-> !DISPLAY_ACTIVE;
   endproperty
   a_float_idle: assert property (p_float_idle) else $error("shown without activity");
   property p_final_blank;
      FINAL_EMPTY_FLAG[*4] |-> !DISPLAY_ACTIVE && !LED_COMMON_OUT && LED_SEGMENT_OUT == 5'h00;
   endproperty
   a_final_blank: assert property (p_final_blank) else $error("shown after final empty");
   property p_banks;
      LED_SEGMENT_OUT != 5'h00 |-> LED_COMMON_OUT && DISPLAY_ACTIVE &&
         ((LED_SEGMENT_OUT & 5'h0A) == 5'h00 || (LED_SEGMENT_OUT & 5'h15) == 5'h00);
   endproperty
   a_banks: assert property (p_banks) else $error("banks mixed");
   property p_bar;
      !(LED_SEGMENT_OUT[4] && !LED_SEGMENT_OUT[2]) && !(LED_SEGMENT_OUT[3] && !LED_SEGMENT_OUT[1]);
   endproperty
   a_bar: assert property (p_bar) else $error("bar has a gap");
   property p_empty_dark;
      (AVAILABLE_CHARGE_COUNT == 16'h0000)[*3] |-> LED_SEGMENT_OUT == 5'h00;
   endproperty
   a_empty_dark: assert property (p_empty_dark) else $error("lit at zero charge");
   property p_bank_len;
      LED_COMMON_OUT |-> run_r < 8'h1E;
   endproperty
   a_bank_len: assert property (p_bank_len) else $error("bank window too long");
   property p_bank_gap;
      !LED_COMMON_OUT && run_r == 8'h1E |-> (!LED_COMMON_OUT)[*8];
   endproperty
   a_bank_gap: assert property (p_bank_gap) else $error("bank gap too short");
   c_bank_a: cover property (LED_SEGMENT_OUT == 5'h15);
   c_bank_b: cover property (LED_SEGMENT_OUT == 5'h0A);
   c_full_window: cover property (run_r == 8'h1E);
endmodule // lcd_top_props

// ===== tb/lcd_led_model.sv
/*
 leds and display switch on the far side of the segment drivers.
 assumes the bench sets the switch mode on rising edges.
*/
module lcd_led_model (
   input wire clk,
   input wire [1:0] mode,
   input wire clear,
   input wire [4:0] seg,
   input wire com,
   output logic den_n = 1'b1,
   output logic den_f = 1'b0,
   output logic [4:0] seen_r = 5'h00
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------
   // switch and lamps
   // ------------------------------
   // mode 0 tied to supply, 1 floating, 2 held low; a floating pad wanders
   always @(posedge clk) begin
      den_n <= (mode == 2'd2) ? 1'b0 : (mode == 2'd1) ? ~den_n : 1'b1;
      den_f <= (mode == 2'd1);
      seen_r <= clear ? 5'h00 : seen_r | (com ? seg : 5'h00);
   end
endmodule // lcd_led_model

// ===== tb/tb_lcd_top.sv
/*
 bench for the led capacity display top with its led and switch model.
 assumes shortened mux and blink periods; full reference is 1000 counts.
*/
module tb_lcd_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------
   // signals and tables
   // ------------------------------
   localparam int MUX = 100;
   localparam int BLK = 400;
   localparam logic [15:0] LN [10] = '{16'h0000, 16'h0001, 16'h00C8, 16'h018F, 16'h0190, 16'h031F, 16'h0320,
      16'h03E8, 16'h03E8, 16'h03E8};
   localparam logic [3:0] LT [10] = '{4'hC, 4'hC, 4'hC, 4'hC, 4'hC, 4'hC, 4'hC, 4'h0, 4'h2, 4'h5};
   localparam logic [4:0] LX [10] = '{5'h00, 5'h01, 5'h03, 5'h03, 5'h07, 5'h0F, 5'h1F, 5'h07, 5'h0F, 5'h1F};
   localparam logic [23:0] FS [7] = '{24'h00_0000, 24'hFF_F05F, 24'hFF_F061, 24'h00_0178, 24'h00_0177,
      24'h00_01F5, 24'h00_01F3};
   logic REF_CLK = 1'b0;
   logic RESETN = 1'b0;
   logic [1:0] mode = 2'd0;
   logic clr = 1'b0;
   logic [15:0] chg = 16'h03E8;
   logic [15:0] full = 16'h03E8;
   logic [3:0] temp = 4'hC;
   logic [7:0] filt = 8'h00;
   logic signed [23:0] sense = 24'sh00_0000;
   logic fe1 = 1'b0;
   logic fe2 = 1'b0;
   wire den_n;
   wire den_f;
   wire [4:0] seg;
   wire [4:0] seen;
   wire com;
   wire act;
   int n_errors = 0;
   int tests_run = 0;
   int c1;
   int cc;
   initial forever #4 REF_CLK = ~REF_CLK;
   lcd_top #(.MUX_CYC(MUX), .BLINK_HALF_CYC(BLK)) u_lcd_top (.REF_CLK(REF_CLK), .RESETN(RESETN),
      .DISPLAY_ENABLE_N(den_n), .DISPLAY_ENABLE_FLOAT(den_f), .AVAILABLE_CHARGE_COUNT(chg),
      .LEARNED_FULL_CAPACITY(full), .TEMPERATURE_GAUGE_REG(temp), .MAGNITUDE_FILTER_REG(filt),
      .SENSE_RATE_UV(sense), .FIRST_EMPTY_FLAG(fe1), .FINAL_EMPTY_FLAG(fe2), .LED_SEGMENT_OUT(seg),
      .LED_COMMON_OUT(com), .DISPLAY_ACTIVE(act));
   lcd_led_model u_lcd_led_model (.clk(REF_CLK), .mode(mode), .clear(clr), .seg(seg), .com(com),
      .den_n(den_n), .den_f(den_f), .seen_r(seen));
   // ------------------------------
   // shared tasks
   // ------------------------------
   task chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge REF_CLK);
   endtask
   // settle first so stale segments never reach the lamp record
   task watch(input int n);
      cyc(3);
      clr <= 1'b1;
      cyc(1);
      clr <= 1'b0;
      c1 = 0;
      cc = 0;
      repeat (n) begin
         @(posedge REF_CLK);
         c1 += seg[0];
         cc += com;
      end
   endtask
   task finish_test;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ------------------------------
   // scenarios
   // ------------------------------
   task t_modes;
      watch(800);
      chk(seen, 5'h00);
      mode <= 2'd2;
      cyc(8);
      chk(act, 1'b1);
      watch(800);
      chk(seen, 5'h1F);
      chk(cc, 16'd480);
      chk(c1, 16'd240);
   endtask
   task t_levels;
      for (int i = 0; i < 10; i++) begin
         chg <= LN[i];
         temp <= LT[i];
         watch(200);
         chk(seen, LX[i]);
      end
      full <= 16'h01F4;
      chg <= 16'h0190;
      temp <= 4'hC;
      watch(200);
      chk(seen, 5'h1F);
      chg <= 16'h00F9;
      watch(200);
      chk(seen, 5'h07);
      full <= 16'h03E8;
      chg <= 16'h03E8;
   endtask
   task t_blink;
      fe1 <= 1'b1;
      watch(800);
      chk(c1, 16'd120);
      chk(cc, 16'd480);
      fe1 <= 1'b0;
   endtask
   task t_final;
      fe2 <= 1'b1;
      cyc(6);
      chk(act, 1'b0);
      watch(200);
      chk(seen, 5'h00);
      fe2 <= 1'b0;
      cyc(8);
      chk(act, 1'b1);
   endtask
   task t_float;
      mode <= 2'd1;
      for (int i = 0; i < 7; i++) begin
         filt <= (i > 4) ? 8'h64 : 8'h00;
         sense <= FS[i];
         cyc(8);
         chk(act, i[0]);
      end
   endtask
   initial begin
      cyc(10);
      RESETN <= 1'b1;
      cyc(6);
      chk(act, 1'b0);
      t_modes();
      t_levels();
      t_blink();
      t_final();
      t_float();
      finish_test();
   end
   initial begin
      cyc(100000);
      n_errors++;
      finish_test();
   end
endmodule // tb_lcd_top

bind lcd_top lcd_top_props u_lcd_top_props (.REF_CLK(REF_CLK), .RESETN(RESETN),
   .DISPLAY_ENABLE_N(DISPLAY_ENABLE_N), .DISPLAY_ENABLE_FLOAT(DISPLAY_ENABLE_FLOAT),
   .AVAILABLE_CHARGE_COUNT(AVAILABLE_CHARGE_COUNT), .SENSE_RATE_UV(SENSE_RATE_UV),
   .FINAL_EMPTY_FLAG(FINAL_EMPTY_FLAG), .LED_SEGMENT_OUT(LED_SEGMENT_OUT), .LED_COMMON_OUT(LED_COMMON_OUT),
   .DISPLAY_ACTIVE(DISPLAY_ACTIVE));
